// ===== core/ima_byte_track.sv
// Byte position counter and destination address matcher for received frames
`timescale 1ns/1ps
module ima_byte_track #(
   parameter int MAC_BYTES = 6
)(
   input logic clk_sys,
   input logic rst,
   input logic rx_valid,
   input logic rx_sof,
   input logic [7:0] rx_data,
   input logic [47:0] switch_mac,
   output logic [8:0] cur_idx,
   output logic [7:0] prev_byte_r,
   output logic da_ok
);
   logic [8:0] cnt_r;
   logic [8:0] cnt_nxt;
   logic [7:0] prev_byte_nxt;
   logic da_ok_r;
   logic da_ok_nxt;

   // Picks address byte i, first byte on the wire is the most significant
   function automatic logic [7:0] mac_byte(input logic [47:0] mac, input logic [2:0] i);
      logic [5:0] sh;
      sh = 6'd40 - {i, 3'b000};
      mac_byte = mac[sh +: 8];
   endfunction

   // Position of the byte now on the bus
   assign cur_idx = rx_sof ? 9'h000 : cnt_r;
   assign da_ok = da_ok_r;

   // Next count, last byte and running address compare
   always_comb
   begin
      cnt_nxt = cnt_r;
      prev_byte_nxt = prev_byte_r;
      da_ok_nxt = da_ok_r;
      if (rx_valid)
      begin
         cnt_nxt = (cur_idx == ima_pkg::IDX_MAX) ? cur_idx : cur_idx + 9'h001;
         prev_byte_nxt = rx_data;
         if (cur_idx < 9'(MAC_BYTES))
         begin
            da_ok_nxt = (rx_sof | da_ok_r) & (rx_data == mac_byte(switch_mac, cur_idx[2:0]));
         end
      end
   end

   // Register stage
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         cnt_r <= 9'h000;
         prev_byte_r <= 8'h00;
         da_ok_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         prev_byte_r <= prev_byte_nxt;
         da_ok_r <= da_ok_nxt;
      end
   end
endmodule

// ===== core/ima_core.sv
// In-band management frame recognition, checking, command issue and response request
`timescale 1ns/1ps
module ima_core (
   input logic clk_sys,
   input logic rst,
   input logic enable_strap_pin,
   input logic [15:0] reg_addr,
   input logic reg_wr,
   input logic reg_rd,
   input logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   input logic [47:0] switch_mac,
   input logic rx_valid,
   input logic rx_sof,
   input logic rx_eof,
   input logic [7:0] rx_data,
   input logic [2:0] rx_port,
   output logic frame_divert,
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output logic [23:0] cmd_arg,
   output logic tx_req,
   output logic [2:0] tx_port,
   output logic [1:0] tx_queue,
   input logic tx_ack
);
   // Control register state
   logic strap_meta_r;
   logic strap_sync_r;
   logic [1:0] strap_wait_r, strap_wait_nxt;
   logic ctrl_en_r, ctrl_en_nxt;
   logic ctrl_dam_r, ctrl_dam_nxt;
   logic mgmt_rst_r, mgmt_rst_nxt;
   logic [1:0] ctrl_pq_r, ctrl_pq_nxt;
   logic [2:0] ctrl_port_r, ctrl_port_nxt;
   logic [15:0] ctrl_etype_r, ctrl_etype_nxt;
   logic [31:0] reg_rdata_nxt;
   logic [31:0] ctrl_word;
   logic [31:0] stat_word;

   // Frame machine and status state
   ima_pkg::ima_state_t state_r, state_nxt;
   logic divert_r, divert_nxt;
   logic drop_r, drop_nxt;
   logic hdr_bad_r, hdr_bad_nxt;
   logic cmd_bad_r, cmd_bad_nxt;
   logic pad_r, pad_nxt;
   logic good_r, good_nxt;
   logic txd_r, txd_nxt;
   logic exd_r, exd_nxt;
   logic mac_err_r, mac_err_nxt;
   logic fmt_err_r, fmt_err_nxt;
   logic code_err_r, code_err_nxt;
   logic cmd_err_r, cmd_err_nxt;
   logic ovs_err_r, ovs_err_nxt;
   logic [6:0] loc_r, loc_nxt;
   logic cmd_valid_r, cmd_valid_nxt;
   logic [7:0] cmd_code_r, cmd_code_nxt;
   logic [23:0] cmd_arg_r, cmd_arg_nxt;

   // Byte tracking
   logic [8:0] cur_idx;
   logic [7:0] prev_byte_r;
   logic da_ok;
   logic byte_ok;
   logic et_hit;
   logic [8:0] cmd_off;

   ima_byte_track #(
      .MAC_BYTES(6)
   ) u_track (
      .clk_sys(clk_sys),
      .rst(rst),
      .rx_valid(rx_valid),
      .rx_sof(rx_sof),
      .rx_data(rx_data),
      .switch_mac(switch_mac),
      .cur_idx(cur_idx),
      .prev_byte_r(prev_byte_r),
      .da_ok(da_ok)
   );

   // Byte qualifiers
   assign byte_ok = rx_valid & (rx_port == ctrl_port_r);
   assign et_hit = ({prev_byte_r, rx_data} == ctrl_etype_r);
   assign cmd_off = cur_idx - ima_pkg::IDX_CMD0;

   // Register images for reads
   always_comb
   begin
      ctrl_word = 32'h0000_0000;
      ctrl_word[ima_pkg::CTRL_EN_BIT] = ctrl_en_r;
      ctrl_word[ima_pkg::CTRL_DAM_BIT] = ctrl_dam_r;
      ctrl_word[ima_pkg::CTRL_RST_BIT] = mgmt_rst_r;
      ctrl_word[ima_pkg::CTRL_PQ_LSB +: 2] = ctrl_pq_r;
      ctrl_word[ima_pkg::CTRL_PORT_LSB +: 3] = ctrl_port_r;
      ctrl_word[ima_pkg::CTRL_ETYPE_LSB +: 16] = ctrl_etype_r;
      stat_word = ima_pkg::STAT_RST;
      stat_word[ima_pkg::STAT_GOOD_BIT] = good_r;
      stat_word[ima_pkg::STAT_TXD_BIT] = txd_r;
      stat_word[ima_pkg::STAT_EXD_BIT] = exd_r;
      stat_word[ima_pkg::STAT_MAC_BIT] = mac_err_r;
      stat_word[ima_pkg::STAT_FMT_BIT] = fmt_err_r;
      stat_word[ima_pkg::STAT_CODE_BIT] = code_err_r;
      stat_word[ima_pkg::STAT_CMD_BIT] = cmd_err_r;
      stat_word[ima_pkg::STAT_OVS_BIT] = ovs_err_r;
      stat_word[ima_pkg::STAT_LOC_LSB +: 7] = cmd_err_r ? loc_r : 7'h00;
   end

   // Control register writes, strap load and read decode
   always_comb
   begin
      strap_wait_nxt = strap_wait_r;
      ctrl_en_nxt = ctrl_en_r;
      ctrl_dam_nxt = ctrl_dam_r;
      mgmt_rst_nxt = 1'b0;
      ctrl_pq_nxt = ctrl_pq_r;
      ctrl_port_nxt = ctrl_port_r;
      ctrl_etype_nxt = ctrl_etype_r;
      reg_rdata_nxt = reg_rdata;
      if (reg_wr && reg_addr == ima_pkg::REG_CTRL_OFS)
      begin
         ctrl_en_nxt = reg_wdata[ima_pkg::CTRL_EN_BIT];
         ctrl_dam_nxt = reg_wdata[ima_pkg::CTRL_DAM_BIT];
         mgmt_rst_nxt = reg_wdata[ima_pkg::CTRL_RST_BIT];
         ctrl_pq_nxt = reg_wdata[ima_pkg::CTRL_PQ_LSB +: 2];
         ctrl_port_nxt = reg_wdata[ima_pkg::CTRL_PORT_LSB +: 3];
         ctrl_etype_nxt = reg_wdata[ima_pkg::CTRL_ETYPE_LSB +: 16];
      end
      if (strap_wait_r != ima_pkg::STRAP_SETTLE)
      begin
         strap_wait_nxt = strap_wait_r + 2'h1;
         if (strap_wait_r == ima_pkg::STRAP_SETTLE - 2'h1)
         begin
            ctrl_en_nxt = ~strap_sync_r;
         end
      end
      if (reg_rd)
      begin
         if (reg_addr == ima_pkg::REG_CTRL_OFS)
         begin
            reg_rdata_nxt = ctrl_word;
         end
         else if (reg_addr == ima_pkg::REG_STAT_OFS)
         begin
            reg_rdata_nxt = stat_word;
         end
         else
         begin
            reg_rdata_nxt = 32'h0000_0000;
         end
      end
   end

   // Strap synchroniser, kept running through reset so the pin level is settled at load time
   always_ff @(posedge clk_sys)
   begin
      strap_meta_r <= enable_strap_pin;
      strap_sync_r <= strap_meta_r;
   end

   // Control register storage
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         strap_wait_r <= 2'h0;
         ctrl_en_r <= 1'b0;
         ctrl_dam_r <= 1'b0;
         mgmt_rst_r <= 1'b0;
         ctrl_pq_r <= ima_pkg::PQ_RST;
         ctrl_port_r <= ima_pkg::PORT_RST;
         ctrl_etype_r <= ima_pkg::ETYPE_RST;
         reg_rdata <= 32'h0000_0000;
      end
      else
      begin
         strap_wait_r <= strap_wait_nxt;
         ctrl_en_r <= ctrl_en_nxt;
         ctrl_dam_r <= ctrl_dam_nxt;
         mgmt_rst_r <= mgmt_rst_nxt;
         ctrl_pq_r <= ctrl_pq_nxt;
         ctrl_port_r <= ctrl_port_nxt;
         ctrl_etype_r <= ctrl_etype_nxt;
         reg_rdata <= reg_rdata_nxt;
      end
   end

   // Frame machine: header checks, command issue, flags and response request
   always_comb
   begin
      state_nxt = state_r;
      divert_nxt = divert_r;
      drop_nxt = drop_r;
      hdr_bad_nxt = hdr_bad_r;
      cmd_bad_nxt = cmd_bad_r;
      pad_nxt = pad_r;
      good_nxt = good_r;
      txd_nxt = txd_r;
      exd_nxt = exd_r;
      mac_err_nxt = mac_err_r;
      fmt_err_nxt = fmt_err_r;
      code_err_nxt = code_err_r;
      cmd_err_nxt = cmd_err_r;
      ovs_err_nxt = ovs_err_r;
      loc_nxt = loc_r;
      cmd_valid_nxt = 1'b0;
      cmd_code_nxt = cmd_code_r;
      cmd_arg_nxt = cmd_arg_r;
      case (state_r)
         ima_pkg::IMA_IDLE:
         begin
            if (byte_ok && rx_sof && !rx_eof && ctrl_en_r)
            begin
               state_nxt = ima_pkg::IMA_HDR;
               drop_nxt = 1'b0;
               hdr_bad_nxt = 1'b0;
               cmd_bad_nxt = 1'b0;
               pad_nxt = 1'b0;
            end
         end
         ima_pkg::IMA_HDR:
         begin
            if (byte_ok)
            begin
               if (cur_idx == ima_pkg::IDX_ETYPE)
               begin
                  if (!et_hit)
                  begin
                     state_nxt = ima_pkg::IMA_IDLE;
                  end
                  else
                  begin
                     divert_nxt = 1'b1;
                     txd_nxt = 1'b0;
                     exd_nxt = 1'b0;
                     fmt_err_nxt = 1'b0;
                     code_err_nxt = 1'b0;
                     cmd_err_nxt = 1'b0;
                     ovs_err_nxt = 1'b0;
                     mac_err_nxt = ctrl_dam_r & ~da_ok;
                     drop_nxt = ctrl_dam_r & ~da_ok;
                  end
               end
               if (cur_idx == ima_pkg::IDX_FMT && {prev_byte_r, rx_data} != ima_pkg::FMT_VALID)
               begin
                  fmt_err_nxt = 1'b1;
                  hdr_bad_nxt = 1'b1;
               end
               if (cur_idx == ima_pkg::IDX_CODE)
               begin
                  state_nxt = ima_pkg::IMA_CMD;
                  if ({prev_byte_r, rx_data} != ima_pkg::CODE_READ &&
                      {prev_byte_r, rx_data} != ima_pkg::CODE_WRITE)
                  begin
                     code_err_nxt = 1'b1;
                     hdr_bad_nxt = 1'b1;
                  end
               end
               if (rx_eof)
               begin
                  state_nxt = ima_pkg::IMA_IDLE;
                  divert_nxt = 1'b0;
               end
            end
         end
         ima_pkg::IMA_CMD:
         begin
            if (byte_ok)
            begin
               if (cur_idx >= ima_pkg::MAX_FRAME_BYTES)
               begin
                  ovs_err_nxt = 1'b1;
               end
               if (cmd_off[1:0] == 2'h0 && !pad_r)
               begin
                  cmd_code_nxt = rx_data;
                  pad_nxt = (rx_data == ima_pkg::CMD_END); // Padding and check bytes are not commands
                  if (rx_data != ima_pkg::CMD_END && rx_data != ima_pkg::CMD_READ &&
                      rx_data != ima_pkg::CMD_WRITE && !cmd_bad_r)
                  begin
                     cmd_err_nxt = 1'b1;
                     cmd_bad_nxt = 1'b1;
                     loc_nxt = cmd_off[8:2];
                  end
               end
               else if (!pad_r)
               begin
                  cmd_arg_nxt = {cmd_arg_r[15:0], rx_data};
               end
               if (cmd_off[1:0] == 2'h3 && cmd_code_r != ima_pkg::CMD_END &&
                   !hdr_bad_r && !drop_r && !cmd_bad_r && !ovs_err_r)
               begin
                  cmd_valid_nxt = 1'b1;
               end
               if (rx_eof)
               begin
                  divert_nxt = 1'b0;
                  if (ovs_err_nxt || drop_r)
                  begin
                     state_nxt = ima_pkg::IMA_IDLE;
                  end
                  else
                  begin
                     state_nxt = ima_pkg::IMA_RESP;
                     good_nxt = good_r | (!hdr_bad_r && !cmd_bad_nxt);
                     exd_nxt = !hdr_bad_r && !cmd_bad_nxt;
                  end
               end
            end
         end
         ima_pkg::IMA_RESP:
         begin
            if (tx_ack)
            begin
               txd_nxt = 1'b1;
               state_nxt = ima_pkg::IMA_IDLE;
            end
         end
         default:
         begin
            state_nxt = ima_pkg::IMA_IDLE;
         end
      endcase
      if (mgmt_rst_r)
      begin
         state_nxt = ima_pkg::IMA_IDLE;
         divert_nxt = 1'b0;
         cmd_valid_nxt = 1'b0;
      end
   end

   // Frame machine storage
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         state_r <= ima_pkg::IMA_IDLE;
         divert_r <= 1'b0;
         drop_r <= 1'b0;
         hdr_bad_r <= 1'b0;
         cmd_bad_r <= 1'b0;
         pad_r <= 1'b0;
         good_r <= 1'b0;
         txd_r <= 1'b0;
         exd_r <= 1'b0;
         mac_err_r <= 1'b0;
         fmt_err_r <= 1'b0;
         code_err_r <= 1'b0;
         cmd_err_r <= 1'b0;
         ovs_err_r <= 1'b0;
         loc_r <= 7'h00;
         cmd_valid_r <= 1'b0;
         cmd_code_r <= 8'h00;
         cmd_arg_r <= 24'h00_0000;
      end
      else
      begin
         state_r <= state_nxt;
         divert_r <= divert_nxt;
         drop_r <= drop_nxt;
         hdr_bad_r <= hdr_bad_nxt;
         cmd_bad_r <= cmd_bad_nxt;
         pad_r <= pad_nxt;
         good_r <= good_nxt;
         txd_r <= txd_nxt;
         exd_r <= exd_nxt;
         mac_err_r <= mac_err_nxt;
         fmt_err_r <= fmt_err_nxt;
         code_err_r <= code_err_nxt;
         cmd_err_r <= cmd_err_nxt;
         ovs_err_r <= ovs_err_nxt;
         loc_r <= loc_nxt;
         cmd_valid_r <= cmd_valid_nxt;
         cmd_code_r <= cmd_code_nxt;
         cmd_arg_r <= cmd_arg_nxt;
      end
   end

   // Outputs toward the switch fabric
   assign frame_divert = divert_r;
   assign cmd_valid = cmd_valid_r;
   assign cmd_code = cmd_code_r;
   assign cmd_arg = cmd_arg_r;
   assign tx_req = (state_r == ima_pkg::IMA_RESP);
   assign tx_port = ctrl_port_r;
   assign tx_queue = ctrl_pq_r;

   // Checks on the strap load and the frame machine
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   sequence et_seen_s;
      state_r == ima_pkg::IMA_HDR && byte_ok && cur_idx == ima_pkg::IDX_ETYPE && et_hit;
   endsequence

   sequence oversize_end_s;
      state_r == ima_pkg::IMA_CMD && byte_ok && rx_eof && ovs_err_nxt;
   endsequence

   strap_load_a: assert property (
      strap_wait_r == ima_pkg::STRAP_SETTLE - 2'h1 && !(reg_wr && reg_addr == ima_pkg::REG_CTRL_OFS)
      |=> ctrl_en_r == !$past(enable_strap_pin, 3))
      else $error("enable bit not loaded from inverted strap");
   da_drop_a: assert property (
      et_seen_s ##0 (ctrl_dam_r && !da_ok) |=> mac_err_r && drop_r ##1 !cmd_valid)
      else $error("address mismatch not dropped");
   da_ignore_a: assert property (
      et_seen_s ##0 !ctrl_dam_r |=> !mac_err_r && !drop_r)
      else $error("address checked while matching off");
   mgmt_reset_a: assert property (
      mgmt_rst_r |=> state_r == ima_pkg::IMA_IDLE && !frame_divert && !mgmt_rst_r)
      else $error("management reset did not idle the machine");
   resp_route_a: assert property (
      tx_req |-> tx_queue == ctrl_pq_r && tx_port == ctrl_port_r)
      else $error("response queue or port wrong");
   tag_clear_a: assert property (
      et_seen_s |=> !txd_r && !exd_r && !fmt_err_r && !code_err_r && !cmd_err_r && !ovs_err_r)
      else $error("flags not cleared on tagged frame");
   fmt_check_a: assert property (
      state_r == ima_pkg::IMA_HDR && byte_ok && cur_idx == ima_pkg::IDX_FMT &&
      {prev_byte_r, rx_data} != ima_pkg::FMT_VALID |=> fmt_err_r)
      else $error("format error not flagged");
   oversize_quiet_a: assert property (
      oversize_end_s |=> !tx_req ##1 !tx_req)
      else $error("response requested for oversized frame");
   tx_done_a: assert property (
      tx_req && tx_ack |=> txd_r && !tx_req)
      else $error("transmit done not set after response");
   cmd_loc_a: assert property (
      cmd_err_r && $past(cmd_err_r) && !mgmt_rst_r |-> $stable(loc_r))
      else $error("command error location changed while held");
endmodule

// ===== include/ima_pkg.sv
// Constants and types of the in-band management frame access block
package ima_pkg;
   // Register byte offsets
   localparam logic [15:0] REG_CTRL_OFS = 16'h0104;
   localparam logic [15:0] REG_STAT_OFS = 16'h0110;
   // Address of the first switch MAC address byte register, feeding switch_mac
   localparam logic [15:0] REG_SWMAC0_OFS = 16'h0302;

   // Control register field positions
   localparam int CTRL_EN_BIT = 31;
   localparam int CTRL_DAM_BIT = 30;
   localparam int CTRL_RST_BIT = 29;
   localparam int CTRL_PQ_LSB = 22;
   localparam int CTRL_PORT_LSB = 16;
   localparam int CTRL_ETYPE_LSB = 0;

   // Control register reset values
   localparam logic [1:0] PQ_RST = 2'h1;
   localparam logic [2:0] PORT_RST = 3'h0;
   localparam logic [15:0] ETYPE_RST = 16'h40FE;

   // Status register field positions
   localparam int STAT_GOOD_BIT = 31;
   localparam int STAT_TXD_BIT = 30;
   localparam int STAT_EXD_BIT = 29;
   localparam int STAT_MAC_BIT = 14;
   localparam int STAT_FMT_BIT = 13;
   localparam int STAT_CODE_BIT = 12;
   localparam int STAT_CMD_BIT = 11;
   localparam int STAT_OVS_BIT = 10;
   localparam int STAT_LOC_LSB = 0;
   localparam logic [31:0] STAT_RST = 32'h0000_0000;

   // Frame content values
   localparam logic [15:0] FMT_VALID = 16'h9800;
   localparam logic [15:0] CODE_READ = 16'h0001;
   localparam logic [15:0] CODE_WRITE = 16'h0002;
   localparam logic [7:0] CMD_END = 8'h00;
   localparam logic [7:0] CMD_READ = 8'h01;
   localparam logic [7:0] CMD_WRITE = 8'h02;

   // Byte positions within a frame, counted from the first destination byte
   localparam logic [8:0] IDX_ETYPE = 9'h00D;
   localparam logic [8:0] IDX_FMT = 9'h00F;
   localparam logic [8:0] IDX_CODE = 9'h011;
   localparam logic [8:0] IDX_CMD0 = 9'h012;
   localparam logic [8:0] IDX_MAX = 9'h1FF;
   // Largest frame, zero padding and check sequence included
   localparam logic [8:0] MAX_FRAME_BYTES = 9'h140;

   // Clocks from reset release until the synchronised strap is valid
   localparam logic [1:0] STRAP_SETTLE = 2'h2;

   // Frame handling states, Gray coded along the usual path
   typedef enum logic [1:0] {
      IMA_IDLE = 2'b00,
      IMA_HDR = 2'b01,
      IMA_CMD = 2'b11,
      IMA_RESP = 2'b10
   } ima_state_t;
endpackage

// ===== testbench/ima_station.sv
// Remote management station: sends frames and acknowledges responses
`timescale 1ns/1ps
module ima_station (
   input logic clk_sys,
   input logic tx_req,
   output logic rx_valid,
   output logic rx_sof,
   output logic rx_eof,
   output logic [7:0] rx_data,
   output logic [2:0] rx_port,
   output logic tx_ack
);
   int ack_wait = 0;
   int cnt = 0;
   // Quiet stream at time zero
   initial
   begin
      rx_valid = 1'b0;
      rx_sof = 1'b0;
      rx_eof = 1'b0;
      rx_data = 8'h5A;
      rx_port = 3'h0;
      tx_ack = 1'b0;
   end
   // Bytes back to back; size kept legal unless a test asks more
   task automatic send(input logic [7:0] fb[$], input logic [2:0] p);
      for (int i = 0; i < fb.size(); i++)
      begin
         @(posedge clk_sys);
         rx_valid <= 1'b1;
         rx_sof <= (i == 0);
         rx_eof <= (i == fb.size() - 1);
         rx_data <= fb[i];
         rx_port <= p;
      end
      @(posedge clk_sys);
      rx_valid <= 1'b0;
      rx_eof <= 1'b0;
      rx_data <= ~fb[fb.size() - 1];
   endtask
   // Acknowledge a response after ack_wait clocks, one-cycle pulse
   always @(posedge clk_sys)
   begin
      if (tx_ack)
         tx_ack <= 1'b0;
      else if (tx_req === 1'b1)
      begin
         tx_ack <= (cnt >= ack_wait);
         cnt <= (cnt >= ack_wait) ? 0 : cnt + 1;
      end
   end
endmodule

// ===== testbench/tb.sv
// Self-checking bench of the in-band management block
`timescale 1ns/1ps
module tb;
   localparam logic [15:0] CA = ima_pkg::REG_CTRL_OFS;
   localparam logic [15:0] SA = ima_pkg::REG_STAT_OFS;
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic enable_strap_pin = 1'b0;
   logic [47:0] switch_mac = 48'h0210_3254_7698;
   logic [15:0] reg_addr = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic [31:0] reg_rdata;
   logic rx_valid, rx_sof, rx_eof, frame_divert, cmd_valid, tx_req, tx_ack;
   logic [7:0] rx_data, cmd_code, last_code;
   logic [2:0] rx_port, tx_port;
   logic [1:0] tx_queue;
   logic [23:0] cmd_arg, last_arg;
   logic tx_q = 1'b0;
   logic div_seen = 1'b0;
   logic [7:0] fr[$];
   int err_total = 0, samples_checked = 0, n_cmd = 0, n_tx = 0;
   logic [15:0] ef[3] = '{16'h9801, 16'h9800, 16'h9800};
   logic [15:0] ec[3] = '{16'h0001, 16'h0003, 16'h0002};
   logic [7:0] eb[3] = '{8'h02, 8'h02, 8'h07};
   logic [31:0] es[3] = '{32'hC000_2000, 32'hC000_1000, 32'hC000_0801};
   int ed[3] = '{0, 0, 1};

   ima_core uut (.clk_sys, .rst, .enable_strap_pin, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
      .switch_mac, .rx_valid, .rx_sof, .rx_eof, .rx_data, .rx_port, .frame_divert, .cmd_valid, .cmd_code,
      .cmd_arg, .tx_req, .tx_port, .tx_queue, .tx_ack);
   ima_station st (.clk_sys, .tx_req, .rx_valid, .rx_sof, .rx_eof, .rx_data, .rx_port, .tx_ack);

   // Clock of 50 ns
   always #25 clk_sys = ~clk_sys;
   // Count commands and response requests, flag any diversion
   always @(posedge clk_sys)
   begin
      tx_q <= tx_req;
      if (cmd_valid === 1'b1)
      begin
         n_cmd <= n_cmd + 1;
         last_arg <= cmd_arg;
         last_code <= cmd_code;
      end
      if (tx_req === 1'b1 && tx_q !== 1'b1)
         n_tx <= n_tx + 1;
      if (frame_divert === 1'b1)
         div_seen <= 1'b1;
   end
   task automatic chk(input string n, input logic [31:0] g, e);
      samples_checked++;
      if (g !== e)
      begin
         err_total++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] e, m);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), reg_rdata & m, e);
   endtask
   // Header, two commands, zero padding, four check bytes
   task automatic build(input logic [47:0] da, input logic [15:0] et, fm, cd, input logic [7:0] c1, c2,
      input int total);
      fr = {da[47:40], da[39:32], da[31:24], da[23:16], da[15:8], da[7:0], 8'h02, 8'h11, 8'h22, 8'h33,
         8'h44, 8'h55, et[15:8], et[7:0], fm[15:8], fm[7:0], cd[15:8], cd[7:0], c1, 8'h01, 8'h02, 8'h03,
         c2, 8'h04, 8'h05, 8'h06};
      while (fr.size() < total - 4)
         fr.push_back(8'h00);
      repeat (4) fr.push_back(8'hA5);
   endtask
   // Send the frame, then wait out any response
   task automatic run(input logic [2:0] p);
      int n;
      n = 0;
      st.send(fr, p);
      repeat (2) @(posedge clk_sys);
      while (tx_req === 1'b1 && n < 100)
      begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 100)
         err_total++;
      repeat (2) @(posedge clk_sys);
   endtask
   task automatic done(input string t);
      $display("test %s done", t);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Test sequence
   initial
   begin
      int k;
      int c0;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rd(CA, 32'h8040_40FE, ALL);
      wr(SA, ALL);
      rd(SA, 32'h0000_0000, ALL);
      rd(16'h0200, 32'h0000_0000, ALL);
      done("reset");
      wr(CA, 32'hC040_40FE);
      build(switch_mac, 16'h40FE, 16'h9800, 16'h0001, 8'h01, 8'h02, 64);
      run(3'h0);
      rd(SA, 32'hE000_0000, ALL);
      chk("cmds", n_cmd, 2);
      chk("arg", {8'h00, last_arg}, 32'h0004_0506);
      chk("code", {24'h0, last_code}, 32'h0000_0002);
      chk("divert", {31'h0, div_seen}, 32'h0000_0001);
      done("good");
      st.ack_wait = 20;
      c0 = n_tx;
      build(switch_mac ^ 48'h1, 16'h40FE, 16'h9800, 16'h0001, 8'h01, 8'h02, 64);
      run(3'h0);
      rd(SA, 32'h0000_4000, 32'h4000_4000);
      chk("resp", n_tx - c0, 0);
      wr(CA, 32'h8040_40FE);
      run(3'h0);
      rd(SA, 32'hE000_0000, ALL);
      done("address");
      for (k = 0; k < 3; k++)
      begin
         c0 = n_cmd;
         build(switch_mac, 16'h40FE, ef[k], ec[k], 8'h01, eb[k], 64);
         run(3'h0);
         rd(SA, es[k], ALL);
         chk("cmds", n_cmd - c0, ed[k]);
      end
      done("errors");
      for (k = 0; k < 2; k++)
      begin
         c0 = n_tx;
         build(switch_mac, 16'h40FE, 16'h9800, 16'h0001, 8'h01, 8'h02, 320 + k * 10);
         run(3'h0);
         rd(SA, k ? 32'h0000_0400 : 32'h4000_0000, 32'h4000_0400);
         chk("resp", n_tx - c0, 1 - k);
      end
      c0 = n_tx;
      build(switch_mac, 16'h1234, 16'h9800, 16'h0001, 8'h01, 8'h02, 64);
      run(3'h0);
      rd(SA, 32'h0000_0400, 32'h4000_0400);
      chk("resp", n_tx - c0, 0);
      done("size");
      wr(CA, 32'h80C1_88B5);
      build(switch_mac, 16'h88B5, 16'h9800, 16'h0001, 8'h01, 8'h02, 64);
      run(3'h0);
      chk("resp", n_tx - c0, 0);
      run(3'h1);
      rd(SA, 32'hE000_0000, ALL);
      chk("port", {29'h0, tx_port}, 32'h0000_0001);
      chk("queue", {30'h0, tx_queue}, 32'h0000_0003);
      done("port");
      wr(CA, 32'hA0C1_88B5);
      rd(CA, 32'h80C1_88B5, ALL);
      c0 = n_tx;
      run(3'h1);
      chk("resp", n_tx - c0, 1);
      wr(CA, 32'h00C1_88B5);
      rd(CA, 32'h00C1_88B5, ALL);
      run(3'h1);
      chk("resp", n_tx - c0, 1);
      done("control");
      // Second reset with the strap high: enable must come up clear
      @(posedge clk_sys);
      enable_strap_pin <= 1'b1;
      rst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rd(CA, 32'h0040_40FE, ALL);
      rd(SA, 32'h0000_0000, ALL);
      done("strap");
      finish_test;
   end
   // Watchdog well beyond the expected run length
   initial
   begin
      #2000000;
      err_total++;
      finish_test;
   end
endmodule
